// ==== design/scr_secondary.sv ====
// Secondary end: cycle requests, rectifier gating, set points, faults, watchdog.
// Assumes comparator inputs synchronous to mclk; link from scr_link_if.
// Summary of operation
// - Primary keeps control until handshake succeeds.
// - Primary listens about 82 ms before switching.
// - Two requests 30 us apart hand over control.
// - Silent window: primary switches on its own.
// - Rectifier on at fall, off below zero.
// - Continuous mode: rectifier off before request.
// - Voltage target 5 V default, 3-30 V.
// - Current set point 15-100%, 0.52% steps.
// - Enforce minimum off time and request rate.
// - Four fault responses; bus switch separate.
// - Faults pull clock line low 55 us.
// - Watchdog restores 5 V, opens switch.
// - Primary start-up rate and current capped.
// - Ramp request rate over 10 ms.
// - Retry if below 3.6 V after ramp.
// - Regulation aborts ramp once valley programmed.
// - Block requests until fall or 30 us.
// - Rectifier only on requested, edged cycles.
// - Protection suspends rectifier; unrequested faults also stop valley switching.
// - Host sets protection command values.
// - Open rectifier pin stops requests.
// - Grounded pin disables rectifier and open check.
//
// Implementation choices: the plain strobed port and the placing of the registers.
`default_nettype none
`include "scr_regs.svh"
module scr_secondary
  import scr_pkg::*;
#(
  parameter int unsigned RAMP_CYC = `SCR_RAMP_CYC,
  parameter int unsigned WDOG_CYC = `SCR_WDOG_CYC,
  parameter int unsigned INT_CYC  = `SCR_INT_CYC
) (
  input  wire logic        mclk,          // 200 MHz clock
  input  wire logic        rst_n,         // Sync reset, active low
  scr_link_if.sec          link,          // Feedback link
  input  wire logic        need_energy,   // Output below target
  input  wire logic        ccm,           // Continuous conduction detected
  input  wire logic        rect_below_0,  // Rectifier voltage below zero
  input  wire logic        ovr_current,   // Current above 3x CC threshold
  input  wire logic        uv_det,        // Output undervoltage
  input  wire logic        ov_det,        // Output overvoltage
  input  wire logic        in_reg,        // Output in regulation
  input  wire logic [15:0] output_sense_code,     // Output voltage, 10 mV/LSB
  input  wire logic        pin_open,      // Rectifier pin load below 200 pF
  input  wire logic        pin_grounded,  // Rectifier pin tied low
  input  wire logic        unreq_fault,   // Unrequested or cross conduction seen
  input  wire logic        valley_prog,   // Valley detect programming done
  input  wire logic [3:0]  addr,          // Register address
  input  wire logic [15:0] wdata,         // Write data
  input  wire logic        wr,            // Write strobe
  input  wire logic        rd,            // Read strobe
  output logic      [15:0] rdata,         // Read data, one cycle later
  output logic             sync_rectifier, // Rectifier gate drive
  output logic             valley_switching, // Valley gating enabled
  output logic             scl_o,         // Clock line pull value
  output logic             scl_oe_n,      // Low while pulling clock line
  output logic             bus_switch_drive, // Series switch on
  output logic             cc_mode,       // Constant-current regulation
  output logic      [15:0] cv_target,     // Voltage target, 10 mV/LSB
  output logic      [7:0]  cc_target      // Current set point
);
  initial begin
    if (RAMP_CYC < 16 || WDOG_CYC < 2 || INT_CYC < 1) $error("scr_secondary: bad parameters");
  end
  typedef struct packed {
    scr_sec_state_t st;
    logic [15:0]    cv;
    logic [7:0]     cc;
    scr_resp_t      uv_rsp;
    scr_resp_t      ov_rsp;
    logic           bus_en;
    logic [1:0]     fault;
    logic [15:0]    since;     // Cycles since last request or conduction end
    logic [15:0]    per;       // Current permitted request period
    logic [31:0]    ramp;
    logic           ramping;
    logic           wait_fwd;
    logic [15:0]    tmo;
    logic           requested;
    logic           sr;
    logic           req;
    logic [15:0]    hs;
    logic [31:0]    wdog;
    logic [15:0]    int_cnt;
    logic           sr_dis;    // Strap caught after reset
    logic           strap_done;
    logic           ccmode;
    logic [15:0]    rdata;
  } scr_sec_t;
  scr_sec_t r;
  scr_sec_t next_r;
  logic     fault_ev;
  logic     prot;
  logic     can_req;
  always_comb begin
    next_r   = r;
    fault_ev = 1'b0;
    prot     = unreq_fault || ovr_current;
    next_r.req = 1'b0;
    if (!r.strap_done) begin
      next_r.strap_done = 1'b1;
      next_r.sr_dis     = pin_grounded;
    end
    if (r.since != 16'hFFFF) next_r.since = r.since + 16'h0001;
    if (link.fwd_fall) next_r.since = 16'h0000;
    if (r.int_cnt != 16'h0000) next_r.int_cnt = r.int_cnt - 16'h0001;
    next_r.wdog = r.wdog + 32'h0000_0001;
    if (r.wait_fwd) begin
      next_r.tmo = r.tmo + 16'h0001;
      if (link.fwd_fall || r.tmo >= 16'(`SCR_FWD_TMO_CYC - 1)) next_r.wait_fwd = 1'b0;
    end
    if (link.fwd_fall && r.requested && !r.sr_dis && !prot) next_r.sr = 1'b1;
    if (link.fwd_fall) next_r.requested = 1'b0;
    if (r.sr && (rect_below_0 || prot)) next_r.sr = 1'b0;
    if (r.ramping) begin
      next_r.ramp = r.ramp + 32'h0000_0001;
      next_r.per  = 16'(`SCR_START_RATE_PER - (((`SCR_START_RATE_PER - `SCR_MAX_RATE_PER)
                        * (64'(r.ramp) * 64'd1024 / 64'(RAMP_CYC))) >> 10));
      if (in_reg && valley_prog) begin
        next_r.ramping = 1'b0;
        next_r.per     = 16'(`SCR_MAX_RATE_PER);
      end else if (r.ramp >= RAMP_CYC - 1) begin
        next_r.ramping = 1'b0;
        next_r.per     = 16'(`SCR_MAX_RATE_PER);
        if (output_sense_code <= 16'(`SCR_UV_36V)) next_r.st = SCR_S_OFF;
      end
    end
    next_r.ccmode = r.ramping && !in_reg && output_sense_code <= 16'(`SCR_UV_36V);
    can_req = !r.wait_fwd && !link.pri_cond && r.since >= 16'(`SCR_MIN_OFF_CYC)
              && r.since >= r.per && (!r.sr_dis ? !pin_open : 1'b1);
    unique case (r.st)
      SCR_S_IDLE: begin
        next_r.st = SCR_S_HS;
        next_r.hs = 16'h0000;
        next_r.req = 1'b1;
      end
      SCR_S_HS: begin
        next_r.hs = r.hs + 16'h0001;
        if (r.hs == 16'(`SCR_HS_GAP_CYC - 1)) begin
          next_r.req     = 1'b1;
          next_r.st      = SCR_S_RUN;
          next_r.ramping = 1'b1;
          next_r.ramp    = 32'h0000_0000;
          next_r.per     = 16'(`SCR_START_RATE_PER);
          // Unanswered second pulse blocks like any request
          next_r.wait_fwd = 1'b1;
          next_r.tmo      = 16'h0000;
        end
      end
      SCR_S_RUN: begin
        if (need_energy && can_req && !(ccm && r.sr)) begin
          next_r.req       = 1'b1;
          next_r.requested = 1'b1;
          next_r.wait_fwd  = 1'b1;
          next_r.tmo       = 16'h0000;
          next_r.since     = 16'h0000;
        end
        if (ccm && need_energy && can_req) next_r.sr = 1'b0;
      end
      SCR_S_OFF: ;
      default: next_r.st = SCR_S_IDLE;
    endcase
    if (uv_det && !r.fault[0]) begin
      fault_ev = 1'b1;
      if (r.uv_rsp == SCR_RSP_RETRY || r.uv_rsp == SCR_RSP_LATCH) next_r.st = SCR_S_OFF;
      if (r.uv_rsp == SCR_RSP_DIS) next_r.bus_en = 1'b0;
    end
    if (ov_det && !r.fault[1]) begin
      fault_ev = 1'b1;
      if (r.ov_rsp == SCR_RSP_RETRY || r.ov_rsp == SCR_RSP_LATCH) next_r.st = SCR_S_OFF;
      if (r.ov_rsp == SCR_RSP_DIS) next_r.bus_en = 1'b0;
    end
    next_r.rdata = 16'h0000;
    if (rd) begin
      unique case (addr)
        `SCR_ADDR_CTRL:   next_r.rdata = {11'h000, r.ov_rsp, r.uv_rsp, r.bus_en};
        `SCR_ADDR_CV:     next_r.rdata = r.cv;
        `SCR_ADDR_CC:     next_r.rdata = {8'h00, r.cc};
        `SCR_ADDR_FAULT:  next_r.rdata = {14'h0000, r.fault};
        `SCR_ADDR_STATUS: next_r.rdata = {9'h000, r.sr_dis, r.ccmode, r.ramping, r.st};
        default:          next_r.rdata = 16'h0000;
      endcase
    end
    if (wr) begin
      next_r.wdog = 32'h0000_0000;
      unique case (addr)
        `SCR_ADDR_CTRL: begin
          next_r.bus_en = wdata[0];
          next_r.uv_rsp = scr_resp_t'(wdata[2:1]);
          next_r.ov_rsp = scr_resp_t'(wdata[4:3]);
        end
        `SCR_ADDR_CV: if (wdata >= 16'(`SCR_CV_MIN) && wdata <= 16'(`SCR_CV_MAX)) next_r.cv = wdata;
        `SCR_ADDR_CC: if (wdata[7:0] >= `SCR_CC_MIN && wdata[7:0] <= `SCR_CC_MAX) next_r.cc = wdata[7:0];
        `SCR_ADDR_FAULT: next_r.fault = r.fault & ~wdata[1:0];
        default: ;
      endcase
    end
    if (uv_det) next_r.fault[0] = 1'b1;                      // Set beats clear
    if (ov_det) next_r.fault[1] = 1'b1;
    if (fault_ev) next_r.int_cnt = 16'(INT_CYC);
    if (r.wdog >= WDOG_CYC - 1) begin
      next_r.cv     = 16'(`SCR_CV_DEFAULT);
      next_r.bus_en = 1'b0;
      next_r.wdog   = 32'h0000_0000;
    end
    if (!rst_n) begin
      next_r = '{st: SCR_S_IDLE, cv: 16'(`SCR_CV_DEFAULT), cc: `SCR_CC_DEFAULT,
                 uv_rsp: SCR_RSP_NONE, ov_rsp: SCR_RSP_NONE, bus_en: 1'b0, fault: 2'b00,
                 since: 16'hFFFF, per: 16'(`SCR_START_RATE_PER), ramp: 32'h0000_0000,
                 ramping: 1'b0, wait_fwd: 1'b0, tmo: 16'h0000, requested: 1'b0, sr: 1'b0,
                 req: 1'b0, hs: 16'h0000, wdog: 32'h0000_0000, int_cnt: 16'h0000,
                 sr_dis: 1'b0, strap_done: 1'b0, ccmode: 1'b0, rdata: 16'h0000};
    end
  end
  always_ff @(posedge mclk) begin
    r <= next_r;
  end
  assign link.cycle_req    = r.req;
  assign sync_rectifier    = r.sr;
  assign valley_switching  = !unreq_fault && !ccm;
  assign scl_o             = 1'b0;
  assign scl_oe_n          = (r.int_cnt == 16'h0000);
  assign bus_switch_drive  = r.bus_en;
  assign cc_mode           = r.ccmode;
  assign cv_target         = r.cv;
  assign cc_target         = r.cc;
  assign rdata             = r.rdata;
endmodule : scr_secondary
`default_nettype wire

// ==== design/scr_regs.svh ====
// Timing counts and field values for the secondary cycle request block.
// Assumes a 200 MHz mclk; included by both ends.
`ifndef SCR_REGS_SVH
`define SCR_REGS_SVH
`define SCR_CLK_MHZ          200
`define SCR_LISTEN_MS        82
`define SCR_LISTEN_CYC       (`SCR_LISTEN_MS * 1000 * `SCR_CLK_MHZ)
`define SCR_HS_GAP_US        30
`define SCR_HS_GAP_CYC       (`SCR_HS_GAP_US * `SCR_CLK_MHZ)
`define SCR_HS_TOL_CYC       (`SCR_HS_GAP_CYC / 4)
`define SCR_FWD_TMO_US       30
`define SCR_FWD_TMO_CYC      (`SCR_FWD_TMO_US * `SCR_CLK_MHZ)
`define SCR_INT_US           55
`define SCR_INT_CYC          (`SCR_INT_US * `SCR_CLK_MHZ)
`define SCR_RAMP_MS          10
`define SCR_RAMP_CYC         (`SCR_RAMP_MS * 1000 * `SCR_CLK_MHZ)
`define SCR_WDOG_CYC         (1000 * 1000 * `SCR_CLK_MHZ)
`define SCR_MIN_OFF_CYC      400
`define SCR_MAX_RATE_PER     1429
`define SCR_START_RATE_PER   2000
`define SCR_CV_DEFAULT       16'h01F4
`define SCR_CV_MIN           16'h012C
`define SCR_CV_MAX           16'h0BB8
`define SCR_CC_MIN           8'h1D
`define SCR_CC_MAX           8'hC0
`define SCR_CC_DEFAULT       8'hC0
`define SCR_UV_36V           16'h0168
`define SCR_ADDR_CTRL        4'h0
`define SCR_ADDR_CV          4'h1
`define SCR_ADDR_CC          4'h2
`define SCR_ADDR_FAULT       4'h3
`define SCR_ADDR_STATUS      4'h4
`define SCR_ADDR_KICK        4'h5
`define SCR_ADDR_PRI_CTRL    4'h0
`define SCR_ADDR_PRI_STATUS  4'h1
`endif

// ==== design/scr_pkg.sv ====
// Types shared by both ends of the secondary cycle request link.
// Assumes scr_regs.svh is on the include path.
`default_nettype none
package scr_pkg;
  typedef enum logic [1:0] {
    SCR_RSP_NONE  = 2'b00,
    SCR_RSP_LATCH = 2'b01,
    SCR_RSP_RETRY = 2'b10,
    SCR_RSP_DIS   = 2'b11
  } scr_resp_t;
  typedef enum logic [3:0] {
    SCR_S_IDLE = 4'b0001,
    SCR_S_HS   = 4'b0010,
    SCR_S_RUN  = 4'b0100,
    SCR_S_OFF  = 4'b1000
  } scr_sec_state_t;
  typedef enum logic [3:0] {
    SCR_P_LISTEN = 4'b0001,
    SCR_P_OWN    = 4'b0010,
    SCR_P_SLAVE  = 4'b0100,
    SCR_P_RETRY  = 4'b1000
  } scr_pri_state_t;
endpackage : scr_pkg
`default_nettype wire

// ==== design/scr_link_if.sv ====
// Isolated feedback link between the secondary controller and primary.
// Assumes one mclk domain; the bench joins both ends through it.
`default_nettype none
interface scr_link_if;
  logic cycle_req;  // Secondary request pulse
  logic fwd_fall;   // Primary conduction end, seen as winding falling edge
  logic pri_cond;   // Primary conducting
  modport sec (output cycle_req, input fwd_fall, input pri_cond);
  modport pri (input cycle_req, output fwd_fall, output pri_cond);
endinterface : scr_link_if
`default_nettype wire

// ==== design/scr_primary.sv ====
// Primary end: wait and listen, handshake detect, own or slave switching.
// Assumes link from scr_link_if; one switching cycle per accepted request.
`default_nettype none
`include "scr_regs.svh"
module scr_primary
  import scr_pkg::*;
#(
  parameter int unsigned LISTEN_CYC = `SCR_LISTEN_CYC,
  parameter int unsigned COND_CYC   = 200
) (
  input  wire logic        mclk,        // 200 MHz clock
  input  wire logic        rst_n,       // Sync reset, active low
  scr_link_if.pri          link,        // Feedback link
  input  wire logic        resume,      // Pulse: power-up, line fault or retry end
  input  wire logic        own_tick,    // Pulse: own-control cycle rate
  input  wire logic [3:0]  addr,        // Register address
  input  wire logic [15:0] wdata,       // Write data
  input  wire logic        wr,          // Write strobe
  input  wire logic        rd,          // Read strobe
  output logic      [15:0] rdata        // Read data, one cycle later
);
  initial begin
    if (LISTEN_CYC < 2 || COND_CYC < 1) $error("scr_primary: bad parameters");
  end
  typedef struct packed {
    scr_pri_state_t st;
    logic [31:0]    tmr;
    logic [15:0]    gap;
    logic           seen;
    logic [15:0]    cond;
    logic [7:0]     ccl_pct;
    logic [15:0]    rdata;
  } scr_pri_t;
  scr_pri_t r;
  scr_pri_t next_r;
  logic     start;
  always_comb begin
    next_r = r;
    start  = 1'b0;
    if (r.cond != 16'h0000) next_r.cond = r.cond - 16'h0001;
    if (r.gap != 16'hFFFF) next_r.gap = r.gap + 16'h0001;
    unique case (r.st)
      SCR_P_LISTEN: begin
        next_r.tmr = r.tmr + 32'h0000_0001;
        if (link.cycle_req) begin
          next_r.seen = 1'b1;
          next_r.gap  = 16'h0000;
          if (r.seen && r.gap >= 16'(`SCR_HS_GAP_CYC - `SCR_HS_TOL_CYC) &&
              r.gap <= 16'(`SCR_HS_GAP_CYC + `SCR_HS_TOL_CYC)) begin
            next_r.st = SCR_P_SLAVE;
          end
        end else if (r.tmr >= LISTEN_CYC - 1) begin
          next_r.st = SCR_P_OWN;
        end
      end
      SCR_P_OWN: begin
        if (own_tick && r.cond == 16'h0000) start = 1'b1;
        if (link.cycle_req) begin
          next_r.gap = 16'h0000;
          if (r.seen && r.gap >= 16'(`SCR_HS_GAP_CYC - `SCR_HS_TOL_CYC) &&
              r.gap <= 16'(`SCR_HS_GAP_CYC + `SCR_HS_TOL_CYC)) next_r.st = SCR_P_SLAVE;
          next_r.seen = 1'b1;
        end
      end
      SCR_P_SLAVE: begin
        if (link.cycle_req && r.cond == 16'h0000) start = 1'b1;
      end
      SCR_P_RETRY: ;
      default: next_r.st = SCR_P_LISTEN;
    endcase
    if (start) begin
      next_r.cond    = 16'(COND_CYC);
      next_r.ccl_pct = (r.st == SCR_P_OWN) ? 8'h4B : 8'h64;
    end
    if (resume) begin
      next_r.st   = SCR_P_LISTEN;
      next_r.tmr  = 32'h0000_0000;
      next_r.seen = 1'b0;
    end
    // Full current limit from the moment the handshake hands over control
    if (next_r.st == SCR_P_SLAVE && r.st != SCR_P_SLAVE) next_r.ccl_pct = 8'h64;
    next_r.rdata = 16'h0000;
    if (rd && addr == `SCR_ADDR_PRI_STATUS) next_r.rdata = {4'h0, r.ccl_pct, r.st};
    if (wr && addr == `SCR_ADDR_PRI_CTRL && wdata[0]) next_r.st = SCR_P_RETRY;
    if (!rst_n) begin
      next_r = '{st: SCR_P_LISTEN, tmr: 32'h0000_0000, gap: 16'hFFFF, seen: 1'b0,
                 cond: 16'h0000, ccl_pct: 8'h4B, rdata: 16'h0000};
    end
  end
  always_ff @(posedge mclk) begin
    r <= next_r;
  end
  assign link.pri_cond = (r.cond != 16'h0000);
  assign link.fwd_fall = (r.cond == 16'h0001);
  assign rdata         = r.rdata;
endmodule : scr_primary
`default_nettype wire

// ==== test/scr_link_props.sv ====
// Link checks between the secondary and primary ends of the request link.
// Assumes one mclk domain; takes the link signals as plain inputs.
`default_nettype none
module scr_link_props #(
  parameter int unsigned COND_CYC = 200
) (
  input wire logic mclk,      // Clock
  input wire logic rst_n,     // Sync reset, active low
  input wire logic cycle_req, // Request pulse
  input wire logic fwd_fall,  // Conduction end pulse
  input wire logic pri_cond   // Primary conducting
);
  logic [15:0] cond_cnt;
  logic [15:0] gap_cnt;
  logic [15:0] fall_cnt;
  logic [1:0]  req_num;
  logic        blocked;
  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cond_cnt <= 16'h0000;
      gap_cnt  <= 16'hFFFF;
      fall_cnt <= 16'hFFFF;
      req_num  <= 2'h0;
      blocked  <= 1'b0;
    end else begin
      cond_cnt <= pri_cond ? cond_cnt + 16'h0001 : 16'h0000;
      gap_cnt  <= cycle_req ? 16'h0000 : gap_cnt + {15'h0000, gap_cnt != 16'hFFFF};
      fall_cnt <= fwd_fall ? 16'h0000 : fall_cnt + {15'h0000, fall_cnt != 16'hFFFF};
      req_num  <= req_num + {1'b0, cycle_req && req_num != 2'h3};
      // Timeout just under the handshake gap, to allow for rounding
      blocked  <= cycle_req || (blocked && !fwd_fall && gap_cnt < 16'h1766);
    end
  end
  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  a_req_pulse: assert property (cycle_req |=> !cycle_req) else $error("request wider than one cycle");
  a_hs_gap: assert property (cycle_req && req_num == 2'h1 |-> gap_cnt >= 16'h176E && gap_cnt <= 16'h1771)
    else $error("handshake pulse gap wrong");
  a_req_block: assert property (cycle_req |-> !blocked) else $error("request before edge or timeout");
  a_min_off: assert property (cycle_req |-> fall_cnt >= 16'h018F) else $error("off time too short");
  a_max_rate: assert property (cycle_req && req_num >= 2'h2 |-> gap_cnt >= 16'h0594)
    else $error("request rate too high");
  a_fall_pulse: assert property (fwd_fall |=> !fwd_fall) else $error("edge pulse too wide");
  a_fall_ends: assert property (fwd_fall |=> !pri_cond) else $error("conduction outlives edge");
  a_cond_len: assert property (fwd_fall |-> pri_cond && cond_cnt == 16'(COND_CYC - 1))
    else $error("conduction length wrong");
endmodule : scr_link_props
`default_nettype wire

// ==== test/secondary_cycle_request_ctrl_tb.sv ====
// Self-checking bench joining both ends of the cycle request link.
// Assumes design files compiled first; long counts shortened by parameters.
`default_nettype none
module secondary_cycle_request_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, pri_rst_n, sec_rst_n, resume, own_tick, p_wr, p_rd, s_wr, s_rd;
  logic        need_energy, ccm, rect_below_0, ovr_current, uv_det, ov_det, in_reg;
  logic        pin_open, pin_grounded, unreq_fault, valley_prog;
  logic        sync_rectifier, valley_switching, scl_o, scl_oe_n, bus_switch_drive, cc_mode;
  logic [3:0]  addr;
  logic [15:0] wdata, output_sense_code, p_rdata, s_rdata, cv_target, d, cv, wv;
  logic [7:0]  cc_target, cc, wc;
  logic [15:0] cv_c [4] = '{16'h012B, 16'h012C, 16'h0BB8, 16'h0BB9};
  logic [7:0]  cc_c [4] = '{8'h1C, 8'h1D, 8'hC0, 8'hC1};
  int          err_total, total_checks, n, m, q;
  int          cyc = 0;
  scr_link_if scr_link_if_inst ();
  scr_primary #(.LISTEN_CYC(2000)) scr_primary_inst (
    .mclk(mclk), .rst_n(pri_rst_n), .link(scr_link_if_inst.pri), .resume(resume), .own_tick(own_tick),
    .addr(addr), .wdata(wdata), .wr(p_wr), .rd(p_rd), .rdata(p_rdata));
  scr_secondary #(.RAMP_CYC(1000), .WDOG_CYC(5000), .INT_CYC(50)) scr_secondary_inst (
    .mclk(mclk), .rst_n(sec_rst_n), .link(scr_link_if_inst.sec), .need_energy(need_energy), .ccm(ccm),
    .rect_below_0(rect_below_0), .ovr_current(ovr_current), .uv_det(uv_det), .ov_det(ov_det),
    .in_reg(in_reg), .output_sense_code(output_sense_code), .pin_open(pin_open), .pin_grounded(pin_grounded),
    .unreq_fault(unreq_fault), .valley_prog(valley_prog), .addr(addr), .wdata(wdata), .wr(s_wr),
    .rd(s_rd), .rdata(s_rdata), .sync_rectifier(sync_rectifier), .valley_switching(valley_switching),
    .scl_o(scl_o), .scl_oe_n(scl_oe_n), .bus_switch_drive(bus_switch_drive), .cc_mode(cc_mode),
    .cv_target(cv_target), .cc_target(cc_target));
  scr_link_props scr_link_props_inst (.mclk(mclk), .rst_n(pri_rst_n & sec_rst_n),
    .cycle_req(scr_link_if_inst.cycle_req), .fwd_fall(scr_link_if_inst.fwd_fall),
    .pri_cond(scr_link_if_inst.pri_cond));
  //////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      err_total++;
      close_out();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] pri_stat(input logic [3:0] st, input logic [7:0] lim);
    return {4'h0, lim, st};
  endfunction : pri_stat
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out();
    if (err_total == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out
  task automatic step(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : step
  task automatic bus_wr(input logic pri, input logic [3:0] a, input logic [15:0] v);
    @(posedge mclk);
    addr  <= a;
    wdata <= v;
    p_wr  <= pri;
    s_wr  <= !pri;
    @(posedge mclk);
    p_wr <= 1'b0;
    s_wr <= 1'b0;
    #1;
  endtask : bus_wr
  task automatic bus_rd(input logic pri, input logic [3:0] a, output logic [15:0] v);
    @(posedge mclk);
    addr <= a;
    p_rd <= pri;
    s_rd <= !pri;
    @(posedge mclk);
    p_rd <= 1'b0;
    s_rd <= 1'b0;
    #1;
    v = pri ? p_rdata : s_rdata;
  endtask : bus_rd
  task automatic restart(input logic sec_on);
    @(posedge mclk);
    pri_rst_n <= 1'b0;
    sec_rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    pri_rst_n <= 1'b1;
    sec_rst_n <= sec_on;
    #1;
  endtask : restart
  // Bounded wait for a request (sel high) or a conduction end
  task automatic wait_ev(input logic sel);
    int k;
    k = 0;
    do begin
      step(1);
      k++;
    end while ((sel ? scr_link_if_inst.cycle_req : scr_link_if_inst.fwd_fall) !== 1'b1 && k < 20000);
    chk(16'(k < 20000), 16'h0001);
  endtask : wait_ev
  task automatic count(input int k);
    {n, m, q} = '0;
    repeat (k) begin
      step(1);
      n += int'(scr_link_if_inst.cycle_req === 1'b1);
      m += int'(sync_rectifier === 1'b1);
      q += int'(scl_oe_n === 1'b0);
    end
  endtask : count
  //////////////////////////////////////////////////////////////////////////
  initial begin
    {pri_rst_n, sec_rst_n, resume, own_tick, p_wr, p_rd, s_wr, s_rd} = 8'h00;
    {need_energy, ccm, rect_below_0, ovr_current, uv_det, ov_det, in_reg} = 7'h40;
    {pin_open, pin_grounded, unreq_fault, valley_prog} = 4'h0;
    {addr, wdata, output_sense_code} = {4'h0, 16'h0000, 16'h01F4};
    {err_total, total_checks} = '0;
    void'($urandom(84));
    restart(1'b1);
    bus_rd(1'b1, 4'h1, d);
    chk({12'h000, d[3:0]}, 16'h0001);
    step(6100);
    bus_rd(1'b1, 4'h1, d);
    chk(d, pri_stat(4'h4, 8'h64));
    {cv, cc} = {16'h01F4, 8'hC0};
    bus_rd(1'b0, 4'h1, d);
    chk(d, cv);
    for (int i = 0; i < 12; i++) begin
      wv = (i < 4) ? cv_c[i] : 16'($urandom_range(4095));
      wc = (i < 4) ? cc_c[i] : 8'($urandom);
      bus_wr(1'b0, 4'h1, wv);
      bus_wr(1'b0, 4'h2, {8'h00, wc});
      cv = (wv >= 16'h012C && wv <= 16'h0BB8) ? wv : cv;
      cc = (wc >= 8'h1D && wc <= 8'hC0) ? wc : cc;
      bus_rd(1'b0, 4'h1, d);
      chk(d, cv);
      chk({8'h00, cc_target}, {8'h00, cc});
    end
    bus_wr(1'b0, 4'h1, 16'h04B0);
    bus_wr(1'b0, 4'h0, 16'h0001);
    step(4000);
    chk(cv_target, 16'h04B0);
    step(1100);
    chk({cv_target[14:0], bus_switch_drive}, {15'h01F4, 1'b0});
    wait_ev(1'b0);
    step(1);
    chk({15'h0000, sync_rectifier}, 16'h0001);
    @(posedge mclk) rect_below_0 <= 1'b1;
    step(2);
    chk({15'h0000, sync_rectifier}, 16'h0000);
    @(posedge mclk) {rect_below_0, ovr_current} <= 2'b01;
    wait_ev(1'b0);
    count(300);
    chk(16'(m), 16'h0000);
    @(posedge mclk) {ovr_current, ccm} <= 2'b01;
    wait_ev(1'b0);
    chk({15'h0000, valley_switching}, 16'h0000);
    wait_ev(1'b1);
    chk({15'h0000, sync_rectifier}, 16'h0000);
    @(posedge mclk) {ccm, unreq_fault} <= 2'b01;
    count(400);
    chk({m[14:0], valley_switching}, 16'h0000);
    @(posedge mclk) unreq_fault <= 1'b0;
    wait_ev(1'b0);
    step(1);
    chk({14'h0000, sync_rectifier, valley_switching}, 16'h0003);
    @(posedge mclk) need_energy <= 1'b0;
    count(2000);
    chk(16'(n), 16'h0000);
    // Ramp abort only counts once valley programming is done
    @(posedge mclk) {output_sense_code, in_reg, valley_prog, need_energy} <= {16'h0100, 3'b101};
    restart(1'b1);
    step(6100);
    bus_rd(1'b0, 4'h4, d);
    chk({15'h0000, d[4]}, 16'h0001);
    @(posedge mclk) valley_prog <= 1'b1;
    step(4);
    bus_rd(1'b0, 4'h4, d);
    chk({15'h0000, d[4]}, 16'h0000);
    @(posedge mclk) {in_reg, valley_prog} <= 2'b00;
    restart(1'b1);
    step(6100);
    chk({15'h0000, cc_mode}, 16'h0001);
    step(1200);
    bus_rd(1'b0, 4'h4, d);
    chk({12'h000, d[3:0]}, 16'h0008);
    @(posedge mclk) output_sense_code <= 16'h01F4;
    for (int i = 0; i < 4; i++) begin
      restart(1'b1);
      step(6100);
      bus_wr(1'b0, 4'h0, 16'h0001 | (16'(i) << (i[0] ? 3 : 1)));
      @(posedge mclk) {ov_det, uv_det} <= i[0] ? 2'b10 : 2'b01;
      count(80);
      chk(16'(q), 16'h0032);
      chk({15'h0000, scl_o}, 16'h0000);
      bus_rd(1'b0, 4'h4, d);
      chk({12'h000, d[3:0]}, (i[0] ^ i[1]) ? 16'h0008 : 16'h0004);
      chk({15'h0000, bus_switch_drive}, {15'h0000, i != 3});
      bus_rd(1'b0, 4'h3, d);
      chk(d & 16'h0003, i[0] ? 16'h0002 : 16'h0001);
      @(posedge mclk) {ov_det, uv_det} <= 2'b00;
    end
    @(posedge mclk) pin_open <= 1'b1;
    restart(1'b1);
    step(11500);
    count(2000);
    chk(16'(n), 16'h0000);
    @(posedge mclk) pin_grounded <= 1'b1;
    restart(1'b1);
    step(11500);
    count(2000);
    chk({16'(n != 0)}, 16'h0001);
    chk(16'(m), 16'h0000);
    bus_rd(1'b0, 4'h4, d);
    chk({15'h0000, d[6]}, 16'h0001);
    @(posedge mclk) {pin_open, pin_grounded} <= 2'b00;
    restart(1'b0);
    step(2100);
    bus_rd(1'b1, 4'h1, d);
    chk(d, pri_stat(4'h2, 8'h4B));
    @(posedge mclk) own_tick <= 1'b1;
    @(posedge mclk) own_tick <= 1'b0;
    step(2);
    chk({15'h0000, scr_link_if_inst.pri_cond}, 16'h0001);
    bus_wr(1'b1, 4'h0, 16'h0001);
    bus_rd(1'b1, 4'h1, d);
    chk({12'h000, d[3:0]}, 16'h0008);
    @(posedge mclk) resume <= 1'b1;
    @(posedge mclk) resume <= 1'b0;
    step(1800);
    bus_rd(1'b1, 4'h1, d);
    chk({12'h000, d[3:0]}, 16'h0001);
    step(300);
    bus_rd(1'b1, 4'h1, d);
    chk({12'h000, d[3:0]}, 16'h0002);
    close_out();
  end
endmodule : secondary_cycle_request_ctrl_tb
`default_nettype wire
